/* File: core/vcac_ctrl.sv */
/*
 * capture channel a control register bank with its reset sequencer,
 * event gating, field id mapping and a sticky interrupt register.
 * assumes the capture logic and dma engine run on aclk and present
 * one-cycle event pulses; software talks axi4-lite.
 */
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module vcac_ctrl (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite slave
    input  wire logic [3:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [3:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // capture side
    input  wire vcac_pkg::vcac_cap_ev_t cap_ev,
    input  wire logic                  dma_req_in,
    input  wire logic                  dma_pending,
    output logic                       dma_event_request,
    output logic                       fifo_flush,
    output logic                       capture_enable_bit,
    output logic                       field_id_active,
    output logic                       field_is_two,
    output logic                       irq
);

    // ************************************************************
    // state
    // ************************************************************
    logic [31:0]                 ctrl_q;
    logic [31:0]                 stat_q;
    logic [vcac_pkg::VCAC_EV_W-1:0] pend_q;
    logic [vcac_pkg::VCAC_EV_W-1:0] mask_q;
    vcac_pkg::vcac_rst_st_t      rst_st_q;
    logic                        hold_q;     // events held off till next field
    logic                        aw_q;
    logic                        w_q;
    logic [3:0]                  awaddr_q;
    logic [31:0]                 wdata_q;
    logic [3:0]                  wstrb_q;

    // ************************************************************
    // decode
    // ************************************************************
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire        aw_have   = aw_q || s_axi_awvalid;
    wire        w_have    = w_q || s_axi_wvalid;
    wire [3:0]  wr_addr   = aw_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data   = w_q ? wdata_q : s_axi_wdata;
    wire [3:0]  wr_strb   = w_q ? wstrb_q : s_axi_wstrb;
    wire        wr_fire   = aw_have && w_have && !s_axi_bvalid;
    wire        wr_ctrl   = wr_fire && (wr_addr == vcac_pkg::VCAC_CTRL_OFS);
    wire        wr_stat   = wr_fire && (wr_addr == vcac_pkg::VCAC_STAT_OFS);
    wire        wr_mask   = wr_fire && (wr_addr == vcac_pkg::VCAC_MASK_OFS);
    wire        wr_irq    = wr_fire && (wr_addr == vcac_pkg::VCAC_IRQ_OFS);
    wire        wr_hit    = wr_ctrl || wr_stat || wr_mask || wr_irq;
    wire        rd_fire   = s_axi_arvalid && !s_axi_rvalid;
    wire        rd_irq    = rd_fire && (s_axi_araddr == vcac_pkg::VCAC_IRQ_OFS);
    wire [31:0] ctrl_wr   = strb_merge(ctrl_q, wr_data, wr_strb);
    wire [31:0] stat_wr   = strb_merge(32'h0000_0000, wr_data, wr_strb);

    // ************************************************************
    // channel behaviour
    // ************************************************************
    wire        blk       = ctrl_q[vcac_pkg::VCAC_BLK_BIT];
    wire        in_reset  = (rst_st_q != vcac_pkg::VCAC_IDLE);
    wire [2:0]  cmode     = ctrl_q[2:0];
    wire        mode_raw  = (cmode >= vcac_pkg::VCAC_MODE_RAW_LO) &&
                            (cmode <= vcac_pkg::VCAC_MODE_RAW_HI);
    wire        mode_vid  = (cmode <= vcac_pkg::VCAC_MODE_YC_HI);
    // a write of one starts the sequence, zero is ignored
    wire        rst_start = wr_ctrl && wr_strb[3] &&
                            wr_data[vcac_pkg::VCAC_RST_BIT] && !in_reset;
    wire        ev_quiet  = blk || in_reset;
    wire        gate_off  = blk || hold_q || in_reset;
    wire        blk_clear = wr_ctrl && wr_strb[3] && blk &&
                            !wr_data[vcac_pkg::VCAC_BLK_BIT];
    wire        rst_done  = (rst_st_q == vcac_pkg::VCAC_FLUSH);
    wire [vcac_pkg::VCAC_EV_W-1:0] ev_now;

    assign ev_now[vcac_pkg::VCAC_EV_FIELD] = cap_ev.field_done && !ev_quiet;
    assign ev_now[vcac_pkg::VCAC_EV_FRAME] = cap_ev.frame_done && !ev_quiet;
    assign ev_now[vcac_pkg::VCAC_EV_VERT]  = cap_ev.vert && !ev_quiet;
    assign ev_now[vcac_pkg::VCAC_EV_RST]   = rst_done;

    // field mapping: invert in video modes, raw id only when enabled
    wire        fid_on    = mode_raw && ctrl_q[vcac_pkg::VCAC_RAWID_BIT];
    wire        fld2_vid  = cap_ev.det_field ^ ctrl_q[vcac_pkg::VCAC_FLDINV_BIT];
    wire        fld2_nxt  = mode_vid ? fld2_vid : (fid_on ? cap_ev.raw_fid : 1'b0);

    // ************************************************************
    // channel reset sequencer
    // ************************************************************
    // waits out pending dma before the flush so no transfer is cut short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_st_q <= vcac_pkg::VCAC_IDLE;
        end else begin
            unique case (rst_st_q)
                vcac_pkg::VCAC_IDLE: begin
                    if (rst_start) rst_st_q <= vcac_pkg::VCAC_DRAIN;
                end
                vcac_pkg::VCAC_DRAIN: begin
                    if (!dma_pending) rst_st_q <= vcac_pkg::VCAC_FLUSH;
                end
                vcac_pkg::VCAC_FLUSH: begin
                    rst_st_q <= vcac_pkg::VCAC_IDLE;
                end
                default: rst_st_q <= vcac_pkg::VCAC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    // reset bit is a live view of the sequencer, so it self-clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= vcac_pkg::VCAC_CTRL_RESET;
        end else if (rst_done) begin
            ctrl_q <= vcac_pkg::VCAC_CTRL_RESET;
        end else if (in_reset) begin
            ctrl_q[vcac_pkg::VCAC_RST_BIT] <= 1'b1;
            ctrl_q[vcac_pkg::VCAC_EN_BIT]  <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q <= (ctrl_wr & vcac_pkg::VCAC_CTRL_WMASK)
                      | {rst_start, 31'h0000_0000};
        end
    end

    // hold events off for the rest of the field in which blocking ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= 1'b0;
        end else if (blk_clear) begin
            hold_q <= 1'b1;
        end else if (cap_ev.field_start) begin
            hold_q <= 1'b0;
        end
    end

    // ************************************************************
    // status flags, write one to clear; a capture in the clear cycle wins
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || rst_done) begin
            stat_q <= 32'h0000_0000;
        end else begin
            if (wr_stat) stat_q <= stat_q & ~stat_wr;
            if (ev_now[vcac_pkg::VCAC_EV_FIELD] && !fld2_nxt)
                stat_q[vcac_pkg::VCAC_FLD1_BIT] <= 1'b1;
            if (ev_now[vcac_pkg::VCAC_EV_FIELD] && fld2_nxt)
                stat_q[vcac_pkg::VCAC_FLD2_BIT] <= 1'b1;
            if (ev_now[vcac_pkg::VCAC_EV_FRAME])
                stat_q[vcac_pkg::VCAC_FRAME_BIT] <= 1'b1;
        end
    end

    // ************************************************************
    // interrupt pending and mask; a read clears, a new event wins
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
            mask_q <= '0;
        end else begin
            pend_q <= (rd_irq ? '0 : pend_q) | ev_now;
            if (wr_mask) mask_q <= wr_data[vcac_pkg::VCAC_EV_W-1:0];
        end
    end

    // ************************************************************
    // channel outputs, all registered
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_event_request  <= 1'b0;
            fifo_flush         <= 1'b1;
            capture_enable_bit <= 1'b0;
            field_id_active    <= 1'b0;
            field_is_two       <= 1'b0;
            irq                <= 1'b0;
        end else begin
            dma_event_request  <= dma_req_in && !gate_off;
            fifo_flush         <= blk || rst_done;
            capture_enable_bit <= ctrl_q[vcac_pkg::VCAC_EN_BIT] && !in_reset;
            field_id_active    <= fid_on || mode_vid;
            field_is_two       <= fld2_nxt;
            irq                <= |(pend_q & mask_q);
        end
    end

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    // address and data are latched in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= 4'h0;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= vcac_pkg::VCAC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? vcac_pkg::VCAC_RESP_OKAY
                                       : vcac_pkg::VCAC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    wire [31:0] rd_mux =
        (s_axi_araddr == vcac_pkg::VCAC_CTRL_OFS) ? ctrl_q :
        (s_axi_araddr == vcac_pkg::VCAC_STAT_OFS) ? stat_q :
        (s_axi_araddr == vcac_pkg::VCAC_IRQ_OFS)  ? {28'h000_0000, pend_q} :
        (s_axi_araddr == vcac_pkg::VCAC_MASK_OFS) ? {28'h000_0000, mask_q} :
        32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= vcac_pkg::VCAC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= vcac_pkg::VCAC_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // handshake readies
    // ************************************************************
    // next-cycle views of the handshake state, so each ready can be a flop
    // and still show exactly what the latched state will allow
    wire        aw_nxt    = !wr_fire && (aw_q || (s_axi_awvalid && s_axi_awready));
    wire        w_nxt     = !wr_fire && (w_q || (s_axi_wvalid && s_axi_wready));
    wire        bv_nxt    = wr_fire || (s_axi_bvalid && !s_axi_bready);
    wire        rv_nxt    = rd_fire || (s_axi_rvalid && !s_axi_rready);

    // registered readies keep every port of the block on a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_awready <= !aw_nxt && !bv_nxt;
            s_axi_wready  <= !w_nxt && !bv_nxt;
            s_axi_arready <= !rv_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: core/vcac_pkg.sv */
/*
 * package for the capture channel a control block: register offsets,
 * field positions, reset values and the small struct that carries
 * capture-side events.
 * assumes an axi4-lite master with 32-bit data on the register side.
 */
package vcac_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] VCAC_CTRL_OFS   = 4'h0;  // capture_channel_a_control
    localparam logic [3:0] VCAC_STAT_OFS   = 4'h4;  // capture_channel_a_status
    localparam logic [3:0] VCAC_IRQ_OFS    = 4'h8;  // sticky events, clear on read
    localparam logic [3:0] VCAC_MASK_OFS   = 4'hC;  // interrupt mask

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int VCAC_RST_BIT   = 31;
    localparam int VCAC_BLK_BIT   = 30;
    localparam int VCAC_RAWID_BIT  = 21;
    localparam int VCAC_FLDINV_BIT = 20;
    localparam int VCAC_EN_BIT    = 15;

    // writable bits: 31..30, 21..15, 12..10, 8..4, 2..0; 29..22 reserved
    localparam logic [31:0] VCAC_CTRL_WMASK = 32'hC03F_9DF7;
    localparam logic [31:0] VCAC_CTRL_RESET = 32'h4002_0030;

    // status bits
    localparam int VCAC_FLD1_BIT  = 28;
    localparam int VCAC_FLD2_BIT  = 29;
    localparam int VCAC_FRAME_BIT = 30;

    // sticky event bits
    localparam int VCAC_EV_FIELD = 0;
    localparam int VCAC_EV_FRAME = 1;
    localparam int VCAC_EV_VERT  = 2;
    localparam int VCAC_EV_RST   = 3;
    localparam int VCAC_EV_W     = 4;

    // capture modes (cmode field 2..0)
    localparam logic [2:0] VCAC_MODE_BT656_LO = 3'h0;
    localparam logic [2:0] VCAC_MODE_YC_HI    = 3'h3;
    localparam logic [2:0] VCAC_MODE_RAW_LO   = 3'h4;
    localparam logic [2:0] VCAC_MODE_RAW_HI   = 3'h5;

    localparam logic [1:0] VCAC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] VCAC_RESP_SLVERR = 2'b10;

    // capture-side events from the field/frame logic
    typedef struct packed {
        logic field_done;   // a field has been captured
        logic frame_done;   // a frame has been captured
        logic vert;         // vertical interrupt point
        logic field_start;  // first line of a new field
        logic raw_fid;      // raw field id input
        logic det_field;    // detected field value
    } vcac_cap_ev_t;

    // reset sequencer states, one-hot
    typedef enum logic [2:0] {
        VCAC_IDLE  = 3'b001,
        VCAC_DRAIN = 3'b010,
        VCAC_FLUSH = 3'b100
    } vcac_rst_st_t;

endpackage

/* File: test/vcac_cap_model.sv */
/* capture-side partner: field events, raw dma requests, dma busy.
   assumes the bench commands it right after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module vcac_cap_model (
    input  wire logic              aclk,
    input  wire logic [3:0]        ev_go,
    input  wire logic              req_go,
    input  wire logic              busy,
    input  wire logic [1:0]        lvl,
    output var vcac_pkg::vcac_cap_ev_t cap_ev = '0,
    output var logic               dma_req_in = 1'b0,
    output var logic               dma_pending = 1'b0
);
    // one-cycle pulses follow the command by one edge; levels are held
    always @(posedge aclk) begin
        cap_ev      <= {ev_go, lvl};
        dma_req_in  <= req_go;
        dma_pending <= busy;
    end
endmodule
`default_nettype wire

/* File: test/vcac_ctrl_sva.sv */
/* checker for vcac_ctrl, bound to its ports.
   assumes full-word control writes and aclk as the only clock. */
`timescale 1ns/1ps
`default_nettype none
module vcac_ctrl_sva (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [3:0]             s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic [31:0]            s_axi_wdata,
    input wire logic [3:0]             s_axi_wstrb,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [3:0]             s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_rvalid,
    input wire vcac_pkg::vcac_cap_ev_t cap_ev,
    input wire logic                   dma_pending,
    input wire logic                   dma_event_request,
    input wire logic                   fifo_flush,
    input wire logic                   capture_enable_bit,
    input wire logic                   field_id_active,
    input wire logic                   field_is_two
);
    // ********************
    // shadow state
    // ********************
    logic [4:0] sh_q;  // raw id enable, field invert, mode as last written
    logic       rs_q;  // channel reset written, its flush not yet seen
    logic       rd_q;  // read in flight targets control
    logic       fs_q;  // field start seen since the flush ended
    wire        wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                         && s_axi_awaddr == vcac_pkg::VCAC_CTRL_OFS && s_axi_wstrb == 4'hF;
    wire        wr_rst = wr_ctl && s_axi_wdata[31];

    // a channel reset returns these fields to zero, so the shadow follows at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_q <= 5'h00;
            rd_q <= 1'b0;
            fs_q <= 1'b0;
            rs_q <= 1'b0;
        end else begin
            if (wr_ctl) sh_q <= wr_rst ? 5'h00 : {s_axi_wdata[21:20], s_axi_wdata[2:0]};
            if (s_axi_arvalid && s_axi_arready) rd_q <= s_axi_araddr == vcac_pkg::VCAC_CTRL_OFS;
            // a field start in the last flushed cycle already ends the hold
            fs_q <= cap_ev.field_start || (fs_q && !fifo_flush);
            rs_q <= wr_rst || (rs_q && !fifo_flush);
        end
    end

    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rst_quiet;
        wr_rst ##1 (!dma_pending) [*3];
    endsequence

    a_no_dma_blk: assert property (dma_event_request |-> !fifo_flush)
        else $error("dma event while flushed");
    a_hold_field: assert property (dma_event_request |-> fs_q)
        else $error("dma event before next field");
    a_rst_en_off: assert property (wr_rst |-> ##[1:2] !capture_enable_bit)
        else $error("capture enable kept on reset");
    a_flush_late: assert property ($rose(fifo_flush) && rs_q |-> !$past(dma_pending, 2))
        else $error("flush during pending dma");
    a_rst_flush: assert property (s_rst_quiet |-> ##[0:2] fifo_flush)
        else $error("no flush after channel reset");
    a_zero_keep: assert property (wr_ctl && !s_axi_wdata[31] && s_axi_wdata[15]
        |-> ##[1:2] capture_enable_bit) else $error("zero reset bit disturbed channel");
    a_fld_video: assert property (sh_q[2:0] < 3'h4 && $stable(sh_q) |=> field_id_active
        && field_is_two == ($past(cap_ev.det_field) ^ $past(sh_q[3]))) else $error("video field");
    a_fld_raw: assert property (sh_q[2:1] == 2'h2 && $stable(sh_q) |=>
        field_id_active == $past(sh_q[4]) && field_is_two == ($past(sh_q[4]) &
        $past(cap_ev.raw_fid))) else $error("raw field id");
    a_rsv_zero: assert property (s_axi_rvalid && rd_q |-> s_axi_rdata[29:22] == 8'h00)
        else $error("reserved bits nonzero");
endmodule

bind vcac_ctrl vcac_ctrl_sva u_vcac_ctrl_sva (.*);
`default_nettype wire

/* File: test/vcac_ctrl_test.sv */
/* self-checking bench for vcac_ctrl with an axi4-lite master.
   assumes the capture model on the far side and 100 MHz aclk. */
`timescale 1ns/1ps
`default_nettype none
module vcac_ctrl_test;
    localparam logic [3:0] CTL = vcac_pkg::VCAC_CTRL_OFS;
    localparam logic [3:0] STA = vcac_pkg::VCAC_STAT_OFS;
    localparam logic [3:0] PND = vcac_pkg::VCAC_IRQ_OFS;
    localparam logic [3:0] MSK = vcac_pkg::VCAC_MASK_OFS;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, busy;
    logic dma_req_in, dma_pending, dma_event_request, fifo_flush, req_go;
    logic capture_enable_bit, field_id_active, field_is_two;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, ev_go;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lvl;
    vcac_pkg::vcac_cap_ev_t cap_ev;
    int miscompares, num_checks, dcnt;

    vcac_ctrl u_vcac_ctrl (.*);
    vcac_cap_model u_vcac_cap_model (.*);

    // ********************
    // bus and compare tasks
    // ********************
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // each channel is released on its own edge, in whichever order it is taken
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // pulses settle through the model and the registered outputs before the caller looks
    task automatic pul(input logic [3:0] e, input logic r);
        ev_go <= e;
        req_go <= r;
        @(posedge aclk);
        ev_go <= 4'h0;
        req_go <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_regs();
        rd(CTL, d);
        chk(d, vcac_pkg::VCAC_CTRL_RESET);
        chk(32'(fifo_flush), 32'h0000_0001);
        wr(CTL, 32'h3FFF_7FFF);
        rd(CTL, d);
        chk(d, 32'h003F_1DF7);
        chk(32'(fifo_flush), 32'h0000_0000);
        $display("t_regs done");
    endtask
    task automatic t_irq();
        wr(MSK, 32'h0000_000F);
        wr(CTL, 32'h0000_0000);
        pul(4'h8, 1'b0);
        chk(32'(irq), 32'h0000_0001);
        rd(STA, d);
        chk(d & 32'h7000_0000, 32'h1000_0000);
        rd(PND, d);
        chk(d & 32'h0000_0001, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0000_0000);
        wr(MSK, 32'h0000_0000);
        pul(4'h8, 1'b0);
        chk(32'(irq), 32'h0000_0000);
        rd(PND, d);
        chk(d & 32'h0000_0001, 32'h0000_0001);
        wr(STA, 32'h7000_0000);
        $display("t_irq done");
    endtask
    task automatic t_dma();
        int n;
        n = dcnt;
        pul(4'h0, 1'b1);
        chk(32'(dcnt), 32'(n));
        pul(4'h1, 1'b0);
        pul(4'h0, 1'b1);
        chk(32'(dcnt), 32'(n + 1));
        wr(CTL, 32'h4000_0000);
        pul(4'hE, 1'b1);
        chk(32'(dcnt), 32'(n + 1));
        rd(STA, d);
        chk(d & 32'h7000_0000, 32'h0000_0000);
        rd(PND, d);
        chk(d & 32'h0000_0007, 32'h0000_0000);
        $display("t_dma done");
    endtask
    task automatic t_mode();
        logic [2:0] m;
        logic [1:0] e;
        for (int i = 0; i < 32; i++) begin
            m = (i[4:3] == 2'h0) ? 3'h0 : (i[4:3] == 2'h1) ? 3'h3 : {2'h2, i[3]};
            lvl <= i[2:1];
            wr(CTL, {10'h000, {2{i[0]}}, 17'h0_0000, m});
            repeat (3) @(posedge aclk);
            e = m[2] ? {i[0], i[0] & i[2]} : {1'b1, i[1] ^ i[0]};
            chk(32'({field_id_active, field_is_two}), 32'(e));
        end
        $display("t_mode done");
    endtask
    task automatic t_chrst();
        for (int j = 0; j < 2; j++) begin
            wr(CTL, 32'h0000_8000);
            repeat (2) @(posedge aclk);
            chk(32'(capture_enable_bit), 32'h0000_0001);
            busy <= (j == 0);
            @(posedge aclk);
            // enable stays set in the written word, so only the reset can clear it
            wr(CTL, 32'h8000_8000);
            rd(CTL, d);
            if (j == 0) chk(d & 32'h8000_8000, 32'h8000_0000);
            chk(32'(capture_enable_bit), 32'h0000_0000);
            busy <= 1'b0;
            for (int i = 0; i < 20 && d[31]; i++) rd(CTL, d);
            chk(d, vcac_pkg::VCAC_CTRL_RESET);
            chk(32'(fifo_flush), 32'h0000_0001);
        end
        $display("t_chrst done");
    endtask

    // ********************
    // clock, reset, run
    // ********************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // counted off the sampling edge so a check never races the count
    always @(negedge aclk) if (dma_event_request === 1'b1) dcnt++;
    initial begin
        repeat (8000) @(posedge aclk);
        miscompares++;
        conclude();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, req_go, busy, ev_go, lvl, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_irq();
        t_dma();
        t_mode();
        t_chrst();
        conclude();
    end
endmodule
`default_nettype wire
